// *** bench/testbench.sv ***
`timescale 1ns/1ps
module testbench;
  typedef struct {logic [7:0] d; logic e; int n; int kind;} sfr_note_s;
  logic clock = 1'b0;
  logic rst = 1'b1;
  logic clockEn = 1'b1;
  logic instValid = 1'b0;
  sfr_pkg::sfr_op_e instOp = sfr_pkg::OP_NOP;
  logic [1:0] instBytes = 2'h1;
  logic [7:0] instAddr = 8'h00;
  logic [7:0] instDest = 8'h00;
  logic [2:0] instBit = 3'h0;
  logic [7:0] instWrData = 8'h00;
  logic instReady, instDone, instError, activePointer;
  logic [7:0] instRdData, uartTxData, lastRd, v;
  logic [31:0] portPinIn = 32'h00000000;
  logic [31:0] portPinOut, portPinOe;
  logic [15:0] uartRxData = 16'h0000;
  logic [1:0] uartTxLoad, p;
  int err_count = 0;
  int check_count = 0;
  int lowCnt = 0;
  sfr_note_s notes[$];
  sfr_note_s nt;

  always #25 clock = ~clock;

  sfr_core dut (.clock(clock), .rst(rst), .clockEn(clockEn), .instValid(instValid), .instOp(instOp),
    .instBytes(instBytes), .instAddr(instAddr), .instDest(instDest), .instBit(instBit),
    .instWrData(instWrData), .instReady(instReady), .instDone(instDone), .instRdData(instRdData),
    .instError(instError), .activePointer(activePointer), .portPinIn(portPinIn), .portPinOut(portPinOut),
    .portPinOe(portPinOe), .uartRxData(uartRxData), .uartTxData(uartTxData), .uartTxLoad(uartTxLoad));

  task automatic check(input logic ok, input string msg);
    check_count++;
    if (ok !== 1'b1) begin
      err_count++;
      $display("ERROR %0t %s", $time, msg);
    end
  endtask

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  // kind: 0 exact data, 1 step from last read, 2 no data, 3 baseline read
  task automatic op(input sfr_pkg::sfr_op_e o, input logic [1:0] b, input logic [7:0] a, input logic [7:0] w,
                    input logic [7:0] d, input logic e, input int kind);
    int n;
    int t;
    n = (o == sfr_pkg::OP_MOVE_DIR) ? ((b < 2) ? 2 : b) : ((b == 0) ? 1 : b) + 1;
    t = 0;
    notes.push_back('{d, e, n, kind});
    while (instReady !== 1'b1 && t < 50) begin
      @(posedge clock);
      #2;
      t++;
    end
    if (t >= 50) begin
      check(1'b0, "ready wait ran out");
      report_and_stop();
    end
    instOp = o;
    instBytes = b;
    instAddr = a;
    instWrData = w;
    instDest = w;
    instBit = w[2:0];
    instValid = 1'b1;
    @(posedge clock);
    #2;
    instValid = 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] d);
    op(sfr_pkg::OP_DIR_RD, 2'h1, a, 8'h00, d, 1'b0, 0);
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] w);
    op(sfr_pkg::OP_DIR_WR, 2'h2, a, w, 8'h00, 1'b0, 2);
  endtask

  // result watcher
  always @(negedge clock) begin
    if (!rst && instDone === 1'b1) begin
      if (notes.size() == 0) begin
        check(1'b0, "completion without request");
      end else begin
        nt = notes.pop_front();
        check(lowCnt == nt.n - 1, "instruction cycle count");
        check(instError === nt.e, "error flag");
        if (nt.kind == 0) check(instRdData === nt.d, "read data");
        if (nt.kind == 1) check(instRdData === lastRd + nt.d, "timer step");
        if (nt.kind != 2) lastRd = instRdData;
      end
      lowCnt = 0;
    end else if (!rst && instReady === 1'b0 && clockEn === 1'b1) begin
      lowCnt++;
    end
  end

  initial begin
    int t;
    v = 8'($urandom(32'ha4c40e4d));
    portPinIn = $urandom();
    uartRxData = 16'($urandom());
    repeat (5) @(posedge clock);
    #2;
    rst = 1'b0;
    check(activePointer === 1'b0 && portPinOut === 32'hffffffff && portPinOe === 32'hffffffff, "reset");
    rd(sfr_pkg::A_SP, sfr_pkg::SP_RESET);
    rd(sfr_pkg::A_PTR_SELECT, sfr_pkg::PTRSEL_RESET);
    rd(sfr_pkg::A_PORT[2], portPinIn[23:16]);
    $display("test reset done");
    wr(sfr_pkg::A_PORT[1], v);
    check(portPinOut[15:8] === v, "port latch");
    op(sfr_pkg::OP_BIT_CLR, 2'h2, sfr_pkg::A_PORT[0], 8'h03, 8'h00, 1'b0, 2);
    check(portPinOut[7:0] === 8'hf7, "port bit clear");
    op(sfr_pkg::OP_BIT_SET, 2'h2, sfr_pkg::A_SP, 8'h01, 8'h00, 1'b1, 2);
    rd(sfr_pkg::A_SP, sfr_pkg::SP_RESET);
    wr(8'h20, 8'h00);
    op(sfr_pkg::OP_BIT_SET, 2'h2, 8'h20, 8'h05, 8'h00, 1'b0, 2);
    rd(8'h20, 8'h20);
    op(sfr_pkg::sfr_op_e'(4'hc), 2'h1, 8'h00, 8'h00, 8'h00, 1'b1, 2);
    $display("test bits done");
    op(sfr_pkg::OP_IND_WR, 2'h1, sfr_pkg::A_PORT[3], v, 8'h00, 1'b0, 2);
    op(sfr_pkg::OP_IND_RD, 2'h1, sfr_pkg::A_PORT[3], 8'h00, v, 1'b0, 0);
    rd(sfr_pkg::A_PORT[3], portPinIn[31:24]);
    check(portPinOut[31:24] === 8'hff, "indirect kept off port");
    $display("test indirect done");
    wr(sfr_pkg::A_PTR0_LO, 8'h10);
    wr(sfr_pkg::A_PTR0_HI, 8'h00);
    wr(sfr_pkg::A_PTR1_LO, 8'hff);
    wr(sfr_pkg::A_PTR1_HI, 8'h03);
    op(sfr_pkg::OP_XWR, 2'h1, 8'h00, v, 8'h00, 1'b0, 2);
    wr(sfr_pkg::A_PTR_SELECT, 8'h01);
    check(activePointer === 1'b1, "pointer select");
    op(sfr_pkg::OP_XWR, 2'h1, 8'h00, ~v, 8'h00, 1'b0, 2);
    wr(sfr_pkg::A_PTR_SELECT, 8'h20);
    op(sfr_pkg::OP_XRD, 2'h1, 8'h00, 8'h00, v, 1'b0, 0);
    check(activePointer === 1'b1, "toggle");
    op(sfr_pkg::OP_XRD, 2'h1, 8'h00, 8'h00, ~v, 1'b0, 0);
    check(activePointer === 1'b0, "toggle back");
    wr(sfr_pkg::A_PTR_SELECT, 8'h08);
    op(sfr_pkg::OP_XRD, 2'h1, 8'h00, 8'h00, v, 1'b0, 0);
    rd(sfr_pkg::A_PTR0_LO, 8'h11);
    wr(sfr_pkg::A_PTR_SELECT, 8'h18);
    op(sfr_pkg::OP_XWR, 2'h1, 8'h00, v, 8'h00, 1'b0, 2);
    rd(sfr_pkg::A_PTR0_LO, 8'h10);
    wr(sfr_pkg::A_PTR0_HI, 8'h04);
    op(sfr_pkg::OP_XRD, 2'h1, 8'h00, 8'h00, 8'h00, 1'b1, 2);
    $display("test pointers done");
    wr(8'h30, v);
    op(sfr_pkg::OP_MOVE_DIR, 2'h3, 8'h30, 8'h31, 8'h00, 1'b0, 2);
    op(sfr_pkg::OP_DIR_RD, 2'h3, 8'h31, 8'h00, v, 1'b0, 0);
    $display("test move done");
    for (int k = 0; k < 2; k++) begin
      wr(sfr_pkg::A_UART[k], v + 8'(k));
      p = uartTxLoad;
      @(posedge clock);
      #2;
      p = p | uartTxLoad;
      check(p === (2'h1 << k) && uartTxData === v + 8'(k), "uart send");
      rd(sfr_pkg::A_UART[k], uartRxData[8*k+:8]);
    end
    $display("test uart done");
    for (int k = 0; k < 3; k++) begin
      wr(sfr_pkg::A_TMR_LO[k], 8'h00);
      wr(sfr_pkg::A_TMR_HI[k], v ^ 8'(k));
      rd(sfr_pkg::A_TMR_HI[k], v ^ 8'(k));
    end
    wr(sfr_pkg::A_TMR_FAST, 8'h07);
    wr(sfr_pkg::A_TMR_RUN, 8'h07);
    for (int k = 0; k < 3; k++) begin
      op(sfr_pkg::OP_DIR_RD, 2'h2, sfr_pkg::A_TMR_LO[k], 8'h00, 8'h00, 1'b0, 3);
      // four frozen edges while busy: neither the timer nor the cycle count may move
      clockEn = 1'b0;
      repeat (4) @(posedge clock);
      #2;
      clockEn = 1'b1;
      op(sfr_pkg::OP_DIR_RD, 2'h2, sfr_pkg::A_TMR_LO[k], 8'h00, 8'h03, 1'b0, 1);
    end
    wr(sfr_pkg::A_TMR_FAST, 8'h00);
    for (int k = 0; k < 3; k++) begin
      op(sfr_pkg::OP_DIR_RD, 2'h2, sfr_pkg::A_TMR_LO[k], 8'h00, 8'h00, 1'b0, 3);
      repeat (39) op(sfr_pkg::OP_NOP, 2'h2, 8'h00, 8'h00, 8'h00, 1'b0, 2);
      op(sfr_pkg::OP_DIR_RD, 2'h2, sfr_pkg::A_TMR_LO[k], 8'h00, 8'h0a, 1'b0, 1);
    end
    $display("test timers done");
    t = 0;
    while (notes.size() > 0 && t < 50) begin
      @(posedge clock);
      t++;
    end
    if (t >= 50) check(1'b0, "results missing");
    report_and_stop();
  end
endmodule // testbench

// *** verilog/sfr_core.sv ***
`timescale 1ns/1ps
module sfr_core (
  // clock, reset, enable
  input wire logic clock,
  input wire logic rst,
  input wire logic clockEn,
  // instruction request
  input wire logic instValid,
  input wire sfr_pkg::sfr_op_e instOp,
  input wire logic [1:0] instBytes,
  input wire logic [7:0] instAddr,
  input wire logic [7:0] instDest,
  input wire logic [2:0] instBit,
  input wire logic [7:0] instWrData,
  // instruction answer
  output logic instReady,
  output logic instDone,
  output logic [7:0] instRdData,
  output logic instError,
  output logic activePointer,
  // port pins
  input wire logic [31:0] portPinIn,
  output logic [31:0] portPinOut,
  output logic [31:0] portPinOe,
  // uart data
  input wire logic [15:0] uartRxData,
  output logic [7:0] uartTxData,
  output logic [1:0] uartTxLoad
);
  sfr_pkg::sfr_state_e state_reg;
  logic [2:0] cnt_reg;
  logic ready_reg;
  logic done_reg;
  logic [7:0] rdData_reg;
  logic error_reg;
  logic [7:0] scratch_reg [sfr_pkg::SCRATCH_DEPTH];
  logic [7:0] xram_reg [sfr_pkg::XMEM_DEPTH];
  logic [15:0] dataPtr_reg [2];
  logic [7:0] ptrSelect_reg;
  logic [7:0] sp_reg;
  logic [7:0] statusWord_reg;
  logic [7:0] acc_reg;
  logic [7:0] b_reg;
  logic [7:0] tmrRun_reg;
  logic [7:0] tmrFast_reg;
  logic [31:0] portLatch_reg;
  logic [31:0] sync1_reg;
  logic [31:0] sync2_reg;
  logic [7:0] txData_reg;
  logic [1:0] txLoad_reg;
  logic [15:0] tmrCount [3];

  // request decode
  logic accept;
  logic isInd;
  logic isBitOp;
  logic isPtrOp;
  logic rmw;
  logic bitOk;
  logic [7:0] sfrRdVal;
  logic [7:0] rdVal;
  logic [7:0] bitMask;
  logic [7:0] wrAddr;
  logic [7:0] wrVal;
  logic doWr;
  logic ramWr;
  logic sfrWr;
  logic ptrSel;
  logic [15:0] actPtr;
  logic xInRange;
  logic [7:0] xRdVal;
  logic xWr;
  logic ptrStep;
  logic ptrDown;
  logic [15:0] stepped;
  logic ptrToggle;
  logic badOp;
  logic [7:0] answer;

  function automatic logic [7:0] sfrRead(logic [7:0] a, logic modify);
    logic [7:0] v;
    v = 8'h00;
    case (a)
      sfr_pkg::A_PORT[0]: v = modify ? portLatch_reg[7:0] : sync2_reg[7:0];
      sfr_pkg::A_PORT[1]: v = modify ? portLatch_reg[15:8] : sync2_reg[15:8];
      sfr_pkg::A_PORT[2]: v = modify ? portLatch_reg[23:16] : sync2_reg[23:16];
      sfr_pkg::A_PORT[3]: v = modify ? portLatch_reg[31:24] : sync2_reg[31:24];
      sfr_pkg::A_SP: v = sp_reg;
      sfr_pkg::A_PTR0_LO: v = dataPtr_reg[0][7:0];
      sfr_pkg::A_PTR0_HI: v = dataPtr_reg[0][15:8];
      sfr_pkg::A_PTR1_LO: v = dataPtr_reg[1][7:0];
      sfr_pkg::A_PTR1_HI: v = dataPtr_reg[1][15:8];
      sfr_pkg::A_PTR_SELECT: v = ptrSelect_reg;
      sfr_pkg::A_TMR_RUN: v = tmrRun_reg;
      sfr_pkg::A_TMR_FAST: v = tmrFast_reg;
      sfr_pkg::A_TMR_LO[0]: v = tmrCount[0][7:0];
      sfr_pkg::A_TMR_HI[0]: v = tmrCount[0][15:8];
      sfr_pkg::A_TMR_LO[1]: v = tmrCount[1][7:0];
      sfr_pkg::A_TMR_HI[1]: v = tmrCount[1][15:8];
      sfr_pkg::A_TMR_LO[2]: v = tmrCount[2][7:0];
      sfr_pkg::A_TMR_HI[2]: v = tmrCount[2][15:8];
      sfr_pkg::A_UART[0]: v = uartRxData[7:0];
      sfr_pkg::A_UART[1]: v = uartRxData[15:8];
      sfr_pkg::A_STATUS_WORD: v = statusWord_reg;
      sfr_pkg::A_ACC: v = acc_reg;
      sfr_pkg::A_BREG: v = b_reg;
      default: v = 8'h00;
    endcase
    return v;
  endfunction

  function automatic logic sfrHit(logic [7:0] a);
    return sfrWr && wrAddr == a;
  endfunction

  assign accept = clockEn && state_reg == sfr_pkg::ST_IDLE && instValid;
  assign isInd = instOp == sfr_pkg::OP_IND_RD || instOp == sfr_pkg::OP_IND_WR;
  assign isBitOp = instOp == sfr_pkg::OP_BIT_RD || instOp == sfr_pkg::OP_BIT_SET || instOp == sfr_pkg::OP_BIT_CLR;
  assign isPtrOp = instOp == sfr_pkg::OP_XRD || instOp == sfr_pkg::OP_XWR || instOp == sfr_pkg::OP_PTR_INC;
  assign rmw = instOp == sfr_pkg::OP_BIT_SET || instOp == sfr_pkg::OP_BIT_CLR;
  assign bitOk = sfr_pkg::isBitAddr(instAddr);
  // sfrRead looks at many registers, so only a process re-evaluates it on their changes
  always_comb begin
    sfrRdVal = sfrRead(instAddr, rmw);
  end
  assign rdVal = (isInd || !instAddr[7]) ? scratch_reg[instAddr] : sfrRdVal;
  assign bitMask = 8'(8'h01 << instBit);
  assign wrAddr = (instOp == sfr_pkg::OP_MOVE_DIR) ? instDest : instAddr;
  assign wrVal = (instOp == sfr_pkg::OP_MOVE_DIR) ? rdVal :
                 (instOp == sfr_pkg::OP_BIT_SET) ? (rdVal | bitMask) :
                 (instOp == sfr_pkg::OP_BIT_CLR) ? (rdVal & ~bitMask) : instWrData;
  assign doWr = accept && (instOp == sfr_pkg::OP_DIR_WR || instOp == sfr_pkg::OP_IND_WR ||
                instOp == sfr_pkg::OP_MOVE_DIR || (rmw && bitOk));
  assign ramWr = doWr && (isInd || !wrAddr[7]);
  assign sfrWr = doWr && !isInd && wrAddr[7];

  // data pointer path
  assign ptrSel = ptrSelect_reg[sfr_pkg::PTRSEL_ACTIVE];
  assign actPtr = dataPtr_reg[ptrSel];
  assign xInRange = actPtr < 16'(sfr_pkg::XMEM_DEPTH);
  assign xRdVal = xInRange ? xram_reg[actPtr[sfr_pkg::XMEM_AW-1:0]] : 8'h00;
  assign xWr = accept && instOp == sfr_pkg::OP_XWR && xInRange;
  assign ptrStep = accept && ((isPtrOp && instOp != sfr_pkg::OP_PTR_INC && ptrSelect_reg[sfr_pkg::PTRSEL_STEP_EN]) ||
                   instOp == sfr_pkg::OP_PTR_INC);
  assign ptrDown = ptrSelect_reg[sfr_pkg::PTRSEL_STEP_DOWN] && instOp != sfr_pkg::OP_PTR_INC;
  assign stepped = ptrDown ? actPtr - 16'h0001 : actPtr + 16'h0001;
  assign ptrToggle = accept && isPtrOp && ptrSelect_reg[sfr_pkg::PTRSEL_TOGGLE];

  // answer selection
  assign badOp = instOp > sfr_pkg::OP_NOP || (isBitOp && !bitOk) ||
                 ((instOp == sfr_pkg::OP_XRD || instOp == sfr_pkg::OP_XWR) && !xInRange);
  assign answer = isBitOp ? {7'h00, rdVal[instBit]} :
                  (instOp == sfr_pkg::OP_XRD) ? xRdVal :
                  (instOp == sfr_pkg::OP_DIR_RD || instOp == sfr_pkg::OP_IND_RD ||
                   instOp == sfr_pkg::OP_MOVE_DIR) ? rdVal : 8'h00;

  // outputs
  assign instReady = ready_reg;
  assign instDone = done_reg;
  assign instRdData = rdData_reg;
  assign instError = error_reg;
  assign activePointer = ptrSelect_reg[sfr_pkg::PTRSEL_ACTIVE];
  assign portPinOut = portLatch_reg;
  assign portPinOe = portLatch_reg;
  assign uartTxData = txData_reg;
  assign uartTxLoad = txLoad_reg;

  // timers
  sfr_tmr_if tmrBus[3] ();
  genvar g;
  generate
    for (g = 0; g < 3; g++) begin : gTmr
      assign tmrBus[g].ce = clockEn;
      assign tmrBus[g].run = tmrRun_reg[g];
      assign tmrBus[g].fast = tmrFast_reg[g];
      assign tmrBus[g].loadLo = sfrWr && wrAddr == sfr_pkg::A_TMR_LO[g];
      assign tmrBus[g].loadHi = sfrWr && wrAddr == sfr_pkg::A_TMR_HI[g];
      assign tmrBus[g].loadData = wrVal;
      assign tmrCount[g] = tmrBus[g].count;
      sfr_timer uTmr (
        .clock(clock),
        .rst(rst),
        .tb(tmrBus[g])
      );
    end
  endgenerate

  // instruction timing
  always_ff @(posedge clock) begin
    if (rst) begin
      state_reg <= sfr_pkg::ST_IDLE;
      cnt_reg <= 3'h0;
      ready_reg <= 1'b1;
      done_reg <= 1'b0;
    end else if (clockEn) begin
      done_reg <= 1'b0;
      unique case (state_reg)
        sfr_pkg::ST_IDLE: begin
          if (instValid) begin
            state_reg <= sfr_pkg::ST_BUSY;
            cnt_reg <= sfr_pkg::instCycles(instOp, instBytes) - 3'h1;
            ready_reg <= 1'b0;
          end
        end
        sfr_pkg::ST_BUSY: begin
          cnt_reg <= cnt_reg - 3'h1;
          if (cnt_reg == 3'h1) begin
            state_reg <= sfr_pkg::ST_IDLE;
            ready_reg <= 1'b1;
            done_reg <= 1'b1;
          end
        end
      endcase
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      rdData_reg <= 8'h00;
      error_reg <= 1'b0;
    end else if (accept) begin
      rdData_reg <= answer;
      error_reg <= badOp;
    end
  end

  // pin synchroniser
  always_ff @(posedge clock) begin
    if (rst) begin
      sync1_reg <= {4{sfr_pkg::PORT_RESET}};
      sync2_reg <= {4{sfr_pkg::PORT_RESET}};
    end else if (clockEn) begin
      sync1_reg <= portPinIn;
      sync2_reg <= sync1_reg;
    end
  end

  // memories
  always_ff @(posedge clock) begin
    if (ramWr) begin
      scratch_reg[wrAddr] <= wrVal;
    end
    if (xWr) begin
      xram_reg[actPtr[sfr_pkg::XMEM_AW-1:0]] <= instWrData;
    end
  end

  // data pointers and select
  always_ff @(posedge clock) begin
    if (rst) begin
      dataPtr_reg[0] <= 16'h0000;
      dataPtr_reg[1] <= 16'h0000;
      ptrSelect_reg <= sfr_pkg::PTRSEL_RESET;
    end else if (clockEn) begin
      if (sfrHit(sfr_pkg::A_PTR0_LO)) begin
        dataPtr_reg[0][7:0] <= wrVal;
      end
      if (sfrHit(sfr_pkg::A_PTR0_HI)) begin
        dataPtr_reg[0][15:8] <= wrVal;
      end
      if (sfrHit(sfr_pkg::A_PTR1_LO)) begin
        dataPtr_reg[1][7:0] <= wrVal;
      end
      if (sfrHit(sfr_pkg::A_PTR1_HI)) begin
        dataPtr_reg[1][15:8] <= wrVal;
      end
      if (ptrStep) begin
        dataPtr_reg[ptrSel] <= stepped;
      end
      if (sfrHit(sfr_pkg::A_PTR_SELECT)) begin
        ptrSelect_reg <= wrVal;
      end else if (ptrToggle) begin
        ptrSelect_reg[sfr_pkg::PTRSEL_ACTIVE] <= ~ptrSel;
      end
    end
  end

  // plain registers, port latches, uart load
  always_ff @(posedge clock) begin
    if (rst) begin
      sp_reg <= sfr_pkg::SP_RESET;
      statusWord_reg <= sfr_pkg::REG_RESET;
      acc_reg <= sfr_pkg::REG_RESET;
      b_reg <= sfr_pkg::REG_RESET;
      tmrRun_reg <= sfr_pkg::REG_RESET;
      tmrFast_reg <= sfr_pkg::REG_RESET;
      portLatch_reg <= {4{sfr_pkg::PORT_RESET}};
      txData_reg <= 8'h00;
      txLoad_reg <= 2'h0;
    end else if (clockEn) begin
      if (sfrHit(sfr_pkg::A_SP)) begin
        sp_reg <= wrVal;
      end
      if (sfrHit(sfr_pkg::A_STATUS_WORD)) begin
        statusWord_reg <= wrVal;
      end
      if (sfrHit(sfr_pkg::A_ACC)) begin
        acc_reg <= wrVal;
      end
      if (sfrHit(sfr_pkg::A_BREG)) begin
        b_reg <= wrVal;
      end
      if (sfrHit(sfr_pkg::A_TMR_RUN)) begin
        tmrRun_reg <= wrVal;
      end
      if (sfrHit(sfr_pkg::A_TMR_FAST)) begin
        tmrFast_reg <= wrVal;
      end
      for (int k = 0; k < 4; k++) begin
        if (sfrHit(sfr_pkg::A_PORT[k])) begin
          portLatch_reg[8*k +: 8] <= wrVal;
        end
      end
      txLoad_reg <= {sfrHit(sfr_pkg::A_UART[1]), sfrHit(sfr_pkg::A_UART[0])};
      if (sfrHit(sfr_pkg::A_UART[0]) || sfrHit(sfr_pkg::A_UART[1])) begin
        txData_reg <= wrVal;
      end
    end
  end

  // checks
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst || !clockEn);

  property p_xrd_two;
    accept && instOp == sfr_pkg::OP_XRD && instBytes == 2'h1 |=> !done_reg ##1 done_reg;
  endproperty
  a_xrd_two: assert property (p_xrd_two) else $error("pointer read not two cycles");

  property p_move_three;
    accept && instOp == sfr_pkg::OP_MOVE_DIR && instBytes == 2'h3 |=> !done_reg ##1 !done_reg ##1 done_reg;
  endproperty
  a_move_three: assert property (p_move_three) else $error("direct move not three cycles");

  property p_byte_plus_one;
    accept && instOp == sfr_pkg::OP_DIR_RD && instBytes == 2'h3 |-> ##4 done_reg && !$past(done_reg, 2);
  endproperty
  a_byte_plus_one: assert property (p_byte_plus_one) else $error("bytes plus one timing off");

  property p_port_latch;
    accept && instOp == sfr_pkg::OP_DIR_WR && instAddr == sfr_pkg::A_PORT[1]
      |=> portLatch_reg[15:8] == $past(instWrData) && portPinOut[15:8] == $past(instWrData);
  endproperty
  a_port_latch: assert property (p_port_latch) else $error("port latch lost write");

  property p_ind_upper;
    accept && instOp == sfr_pkg::OP_IND_WR && instAddr[7]
      |=> $stable(portLatch_reg) && scratch_reg[$past(instAddr)] == $past(instWrData);
  endproperty
  a_ind_upper: assert property (p_ind_upper) else $error("indirect write reached a register");

  property p_bit_refuse;
    accept && rmw && instAddr[7] && instAddr[2:0] != 3'h0 |=> error_reg;
  endproperty
  a_bit_refuse: assert property (p_bit_refuse) else $error("bit op on non-bit address taken");

  property p_toggle;
    accept && instOp == sfr_pkg::OP_XRD && ptrSelect_reg[sfr_pkg::PTRSEL_TOGGLE] |=> activePointer != $past(ptrSel);
  endproperty
  a_toggle: assert property (p_toggle) else $error("pointer select did not flip");

  property p_step_up;
    accept && instOp == sfr_pkg::OP_XRD && ptrSelect_reg[sfr_pkg::PTRSEL_STEP_EN] &&
      !ptrSelect_reg[sfr_pkg::PTRSEL_STEP_DOWN] && !ptrSel |=> dataPtr_reg[0] == $past(dataPtr_reg[0]) + 16'h0001;
  endproperty
  a_step_up: assert property (p_step_up) else $error("active pointer did not step");

  property p_sel_read;
    accept && instOp == sfr_pkg::OP_XRD |=> instRdData == $past(xRdVal);
  endproperty
  a_sel_read: assert property (p_sel_read) else $error("read not from active pointer");

  property p_uart_load;
    accept && instOp == sfr_pkg::OP_DIR_WR && instAddr == sfr_pkg::A_UART[0]
      |=> uartTxLoad[0] && uartTxData == $past(instWrData) ##1 !uartTxLoad[0];
  endproperty
  a_uart_load: assert property (p_uart_load) else $error("uart write not a one-cycle load");

  c_toggle_read: cover property (accept && instOp == sfr_pkg::OP_XRD && ptrSelect_reg[sfr_pkg::PTRSEL_TOGGLE]);
  c_move_done: cover property (accept && instOp == sfr_pkg::OP_MOVE_DIR ##3 done_reg);
  c_port_bit: cover property (accept && instOp == sfr_pkg::OP_BIT_CLR && instAddr == sfr_pkg::A_PORT[0]);
endmodule // sfr_core

// *** verilog/sfr_pkg.sv ***
// Operation
// - one machine cycle lasts exactly one oscillator clock
// - no dummy cycles; every cycle of an instruction does useful work (the core does all work in the accept cycle and only counts down the rest)
// - after reset every timer advances once per twelve clocks
// - each timer can be switched to advance once per clock
// - special registers sit at 80h-FFh, reached by direct addressing only
// - registers at addresses ending 0h or 8h allow single-bit operations
// - two data pointers; select bit 0 picks the active one
// - select bit 5 flips the active pointer on each pointer instruction
// - optional automatic increment or decrement of the active pointer on use
// - instruction takes one cycle per byte plus one execution cycle, except direct-to-direct move
// - pointer data read takes two cycles; direct-to-direct move three
// - results and flag effects match the classic core; only timing differs
// - four 8-bit port registers; each latch keeps the last written value
// - each 16-bit timer is two readable, writable register locations
// - each UART uses one address; reads get receive, writes transmit
// - stack pointer is a free read/write register over scratchpad
// - 256 bytes scratchpad plus 1kB on-chip external-data RAM
package sfr_pkg;
  localparam int CLOCK_HZ = 20000000;
  localparam logic [7:0] A_PORT [4] = '{8'h80, 8'h90, 8'ha0, 8'hb0};
  localparam logic [7:0] A_SP = 8'h81;
  localparam logic [7:0] A_PTR0_LO = 8'h82;
  localparam logic [7:0] A_PTR0_HI = 8'h83;
  localparam logic [7:0] A_PTR1_LO = 8'h84;
  localparam logic [7:0] A_PTR1_HI = 8'h85;
  localparam logic [7:0] A_PTR_SELECT = 8'h86;
  localparam logic [7:0] A_TMR_RUN = 8'h88;
  localparam logic [7:0] A_TMR_FAST = 8'h8e;
  localparam logic [7:0] A_TMR_LO [3] = '{8'h8a, 8'h8b, 8'hcc};
  localparam logic [7:0] A_TMR_HI [3] = '{8'h8c, 8'h8d, 8'hcd};
  localparam logic [7:0] A_UART [2] = '{8'h99, 8'hc1};
  localparam logic [7:0] A_STATUS_WORD = 8'hd0;
  localparam logic [7:0] A_ACC = 8'he0;
  localparam logic [7:0] A_BREG = 8'hf0;
  localparam logic [7:0] BIT_RAM_LO = 8'h20;
  localparam logic [7:0] BIT_RAM_HI = 8'h2f;
  localparam int PTRSEL_ACTIVE = 0;
  localparam int PTRSEL_STEP_EN = 3;
  localparam int PTRSEL_STEP_DOWN = 4;
  localparam int PTRSEL_TOGGLE = 5;
  localparam logic [7:0] PTRSEL_RESET = 8'h00;
  localparam logic [7:0] SP_RESET = 8'h07;
  localparam logic [7:0] PORT_RESET = 8'hff;
  localparam logic [7:0] REG_RESET = 8'h00;
  localparam logic [3:0] TMR_DIV = 4'hc;
  localparam logic [3:0] TMR_PRE_LAST = TMR_DIV - 4'h1;
  localparam int SCRATCH_DEPTH = 256;
  localparam int XMEM_AW = 10;
  localparam int XMEM_DEPTH = 1 << XMEM_AW;

  typedef enum logic [3:0] {
    OP_DIR_RD = 4'h0,
    OP_DIR_WR = 4'h1,
    OP_IND_RD = 4'h2,
    OP_IND_WR = 4'h3,
    OP_BIT_RD = 4'h4,
    OP_BIT_SET = 4'h5,
    OP_BIT_CLR = 4'h6,
    OP_MOVE_DIR = 4'h7,
    OP_XRD = 4'h8,
    OP_XWR = 4'h9,
    OP_PTR_INC = 4'ha,
    OP_NOP = 4'hb
  } sfr_op_e;

  typedef enum logic {
    ST_IDLE = 1'b0,
    ST_BUSY = 1'b1
  } sfr_state_e;

  function automatic logic [2:0] instCycles(sfr_op_e op, logic [1:0] nb);
    logic [2:0] n;
    n = (nb == 2'h0) ? 3'h1 : {1'b0, nb};
    if (op == OP_MOVE_DIR) begin
      return (n < 3'h2) ? 3'h2 : n;
    end
    return n + 3'h1;
  endfunction

  function automatic logic isBitAddr(logic [7:0] a);
    return a[7] ? (a[2:0] == 3'h0) : (a >= BIT_RAM_LO && a <= BIT_RAM_HI);
  endfunction
endpackage

// *** verilog/sfr_timer.sv ***
`timescale 1ns/1ps
module sfr_timer (
  // clock and reset
  input wire logic clock,
  input wire logic rst,
  // control and count
  sfr_tmr_if.timer tb
);
  logic [3:0] pre_reg;
  logic [15:0] count_reg;
  logic tick;
  logic loading;

  assign tick = tb.run && (tb.fast || pre_reg == sfr_pkg::TMR_PRE_LAST);
  assign loading = tb.loadLo || tb.loadHi;
  assign tb.count = count_reg;

  always_ff @(posedge clock) begin
    if (rst) begin
      pre_reg <= 4'h0;
      count_reg <= 16'h0000;
    end else if (tb.ce) begin
      pre_reg <= (pre_reg == sfr_pkg::TMR_PRE_LAST) ? 4'h0 : pre_reg + 4'h1;
      if (tb.loadLo) begin
        count_reg[7:0] <= tb.loadData;
      end else if (tb.loadHi) begin
        count_reg[15:8] <= tb.loadData;
      end else if (tick) begin
        count_reg <= count_reg + 16'h0001;
      end
    end
  end

  property p_slow_hold;
    @(posedge clock) disable iff (rst || !tb.ce)
    tb.run && !tb.fast && !loading && pre_reg != sfr_pkg::TMR_PRE_LAST |=> $stable(count_reg);
  endproperty
  a_slow_hold: assert property (p_slow_hold) else $error("timer moved off its twelfth clock");

  property p_fast_step;
    @(posedge clock) disable iff (rst || !tb.ce)
    tb.run && tb.fast && !loading |=> count_reg == $past(count_reg) + 16'h0001;
  endproperty
  a_fast_step: assert property (p_fast_step) else $error("fast timer missed a clock");

  property p_slow_wrap;
    @(posedge clock) disable iff (rst || !tb.ce)
    tb.run && !tb.fast && !loading && pre_reg == sfr_pkg::TMR_PRE_LAST |=> count_reg == $past(count_reg) + 16'h0001;
  endproperty
  a_slow_wrap: assert property (p_slow_wrap) else $error("slow timer missed its step");
endmodule // sfr_timer

// *** verilog/sfr_tmr_if.sv ***
`timescale 1ns/1ps
interface sfr_tmr_if;
  logic ce;
  logic run;
  logic fast;
  logic loadLo;
  logic loadHi;
  logic [7:0] loadData;
  logic [15:0] count;
  modport ctrl (output ce, output run, output fast, output loadLo, output loadHi, output loadData, input count);
  modport timer (input ce, input run, input fast, input loadLo, input loadHi, input loadData, output count);
endinterface
